//--- fics_pkg.sv
// Package: constants, register map and state encodings of the fast interrupt context swap
package fics_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the APB)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_PTR_HIGH = 8'h04;
    localparam logic [7:0] ADDR_PTR_LOW = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0c;
    localparam logic [7:0] ADDR_SHADOW = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MODE_GIE_BIT = 0;
    localparam int MODE_FEN_BIT = 1;
    localparam int MODE_SEL_LSB = 2;
    localparam int FLAGS_FSF_BIT = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [15:0] PC_RESET = 16'h0100;
    localparam logic [7:0] SP_RESET = 8'hff;

    // ------------------------------------------------------------
    // Timing: cycles of each entry path
    // ------------------------------------------------------------
    localparam int FAST_CYCLES = 6;
    localparam int SLOW_CYCLES = 16;
    localparam logic [4:0] FAST_LAST = 5'(FAST_CYCLES - 1);
    localparam logic [4:0] SLOW_LAST = 5'(SLOW_CYCLES - 1);

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FAST_IN = 3'b001,
        ST_SLOW_IN = 3'b010,
        ST_FAST_OUT = 3'b011,
        ST_SLOW_OUT = 3'b100
    } fics_state_t;

endpackage

//--- fics_apb_decode.sv
// APB slave decode: select strobes and read mux for the fast swap registers
`timescale 1ns/100ps
module fics_apb_decode (
    // APB request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    // Register contents
    input wire logic [7:0] modeVal,
    input wire logic [15:0] ptrVal,
    input wire logic [7:0] flagsVal,
    input wire logic [7:0] shadowVal,
    input wire logic [7:0] statusVal,
    // Decoded outputs
    output logic wrMode,
    output logic wrPtrHigh,
    output logic wrPtrLow,
    output logic wrFlags,
    output logic [31:0] rdData,
    output logic addrBad
);
    wire logic access = psel & penable;
    wire logic hitMode = (paddr == fics_pkg::ADDR_MODE);
    wire logic hitHigh = (paddr == fics_pkg::ADDR_PTR_HIGH);
    wire logic hitLow = (paddr == fics_pkg::ADDR_PTR_LOW);
    wire logic hitFlags = (paddr == fics_pkg::ADDR_FLAGS);
    wire logic hitShadow = (paddr == fics_pkg::ADDR_SHADOW);
    wire logic hitStatus = (paddr == fics_pkg::ADDR_STATUS);

    assign wrMode = access & pwrite & hitMode;
    assign wrPtrHigh = access & pwrite & hitHigh;
    assign wrPtrLow = access & pwrite & hitLow;
    assign wrFlags = access & pwrite & hitFlags;
    assign addrBad = ~(hitMode | hitHigh | hitLow | hitFlags | hitShadow | hitStatus);
    assign rdData = hitMode ? {24'h000000, modeVal} :
                    hitHigh ? {24'h000000, ptrVal[15:8]} :
                    hitLow ? {24'h000000, ptrVal[7:0]} :
                    hitFlags ? {24'h000000, flagsVal} :
                    hitShadow ? {24'h000000, shadowVal} :
                    hitStatus ? {24'h000000, statusVal} : 32'h00000000;
endmodule

//--- fics_core.sv
// Fast interrupt entry and return sequencer with its APB register file
//
// Function
// RL1 - Software loads pointer, then selection field, then sets fast enable.
// RL2 - Fast entry swaps program counter and service-address pointer.
// RL3 - Fast entry copies flags into the shadow flags register.
// RL4 - Fast entry sets the fast-service flag in the flags register.
// RL5 - Return with fast-service flag set swaps counter and pointer back.
// RL6 - Fast return restores flags from the shadow flags register.
// RL7 - Fast return clears the fast-service flag by itself.
// RL8 - Fast path works whatever clears the level's pending condition.
// RL9 - Only the fast enable bit turns the fast path on or off.
// RL10 - Global interrupt enable gates fast interrupts like ordinary ones.
// RL11 - Software should reload the pointer before the fast routine ends.
// RL12 - Fast entry takes 6 cycles, the stacked path 16 cycles.
// RL13 - Pointer is a high byte and a low byte register, 16 bits.
// RL14 - Fast-service flag set blocks interrupts and selects fast return.
// RL15 - Any level zero to seven may be selected for fast service.
// RL16 - Otherwise the ordinary stacked vectored entry is used.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module fics_core (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt request logic
    input wire logic irqValid,
    input wire logic [2:0] irqLevel,
    input wire logic [15:0] vectorAddr,
    output logic irqAck,
    // Program sequencer
    input wire logic irqReturn,
    input wire logic [15:0] pcIn,
    input wire logic pcLoad,
    output logic [15:0] programCounter,
    output logic stackPush,
    output logic stackPop,
    output logic [7:0] stackPtr,
    output logic busy
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] modeReg, modeNext;
    logic [7:0] pointerHighByteReg, pointerHighByteNext;
    logic [7:0] pointerLowByteReg, pointerLowByteNext;
    logic [7:0] flagsReg, flagsNext;
    logic [7:0] shadowReg, shadowNext;
    logic [15:0] pcReg, pcNext;
    logic [7:0] spReg, spNext;
    logic [15:0] savedPcReg, savedPcNext;
    logic [7:0] savedFlagsReg, savedFlagsNext;
    logic [4:0] cntReg, cntNext;
    fics_pkg::fics_state_t stateReg, stateNext;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic wrMode, wrPtrHigh, wrPtrLow, wrFlags, addrBad;
    wire logic [31:0] rdData;
    wire logic [15:0] servicePointer = {pointerHighByteReg, pointerLowByteReg};
    wire logic [7:0] statusVal = {5'h00, stateReg};

    fics_apb_decode uDecode (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .modeVal(modeReg),
        .ptrVal(servicePointer),
        .flagsVal(flagsReg),
        .shadowVal(shadowReg),
        .statusVal(statusVal),
        .wrMode(wrMode),
        .wrPtrHigh(wrPtrHigh),
        .wrPtrLow(wrPtrLow),
        .wrFlags(wrFlags),
        .rdData(rdData),
        .addrBad(addrBad)
    );

    assign pready = 1'b1;
    assign pslverr = psel & penable & addrBad;
    assign prdata = rdData;

    // ------------------------------------------------------------
    // Take decision
    // ------------------------------------------------------------
    wire logic globalOn = modeReg[fics_pkg::MODE_GIE_BIT];
    wire logic fastOn = modeReg[fics_pkg::MODE_FEN_BIT];
    wire logic [2:0] fastLevel = modeReg[fics_pkg::MODE_SEL_LSB +: 3];
    wire logic fastFlag = flagsReg[fics_pkg::FLAGS_FSF_BIT];
    wire logic idle = (stateReg == fics_pkg::ST_IDLE);
    // Fast flag blocks all interrupts; global enable gates both paths
    wire logic takeIrq = idle & irqValid & globalOn & ~fastFlag; // see RL10 see RL14
    // Fast enable and level compare pick the path; pending type is not looked at
    wire logic useFast = fastOn & (irqLevel == fastLevel); // see RL9 see RL15 see RL8
    wire logic takeFast = takeIrq & useFast;
    wire logic takeSlow = takeIrq & ~useFast; // see RL16
    wire logic retFast = idle & irqReturn & fastFlag; // see RL14
    wire logic retSlow = idle & irqReturn & ~fastFlag;
    wire logic lastFast = (cntReg == fics_pkg::FAST_LAST);
    wire logic lastSlow = (cntReg == fics_pkg::SLOW_LAST);

    assign irqAck = takeIrq;
    assign busy = ~idle;
    assign programCounter = pcReg;
    assign stackPtr = spReg;
    assign stackPush = (stateReg == fics_pkg::ST_SLOW_IN) & (cntReg < 5'h03);
    assign stackPop = (stateReg == fics_pkg::ST_SLOW_OUT) & (cntReg < 5'h03);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        stateNext = stateReg;
        cntNext = idle ? 5'h00 : cntReg + 5'h01;
        pcNext = pcLoad & idle ? pcIn : pcReg;
        spNext = spReg;
        savedPcNext = savedPcReg;
        savedFlagsNext = savedFlagsReg;
        flagsNext = wrFlags ? pwdata[7:0] : flagsReg;
        shadowNext = shadowReg;
        pointerHighByteNext = wrPtrHigh ? pwdata[7:0] : pointerHighByteReg; // see RL13 see RL11
        pointerLowByteNext = wrPtrLow ? pwdata[7:0] : pointerLowByteReg; // see RL13
        modeNext = wrMode ? pwdata[7:0] : modeReg; // see RL1
        unique case (stateReg)
            fics_pkg::ST_IDLE: begin
                if (takeFast) begin
                    stateNext = fics_pkg::ST_FAST_IN;
                    pcNext = servicePointer; // see RL2
                    {pointerHighByteNext, pointerLowByteNext} = pcReg; // see RL2
                    shadowNext = flagsReg; // see RL3
                    flagsNext = flagsReg | (8'h01 << fics_pkg::FLAGS_FSF_BIT); // see RL4
                    modeNext[fics_pkg::MODE_GIE_BIT] = 1'b0;
                end else if (takeSlow) begin
                    stateNext = fics_pkg::ST_SLOW_IN;
                    savedPcNext = pcReg;
                    savedFlagsNext = flagsReg;
                    modeNext[fics_pkg::MODE_GIE_BIT] = 1'b0;
                end else if (retFast) begin
                    stateNext = fics_pkg::ST_FAST_OUT;
                    pcNext = servicePointer; // see RL5
                    {pointerHighByteNext, pointerLowByteNext} = pcReg; // see RL5
                    flagsNext = shadowReg & ~(8'h01 << fics_pkg::FLAGS_FSF_BIT); // see RL6 see RL7
                    modeNext[fics_pkg::MODE_GIE_BIT] = 1'b1;
                end else if (retSlow) begin
                    stateNext = fics_pkg::ST_SLOW_OUT;
                end
            end
            fics_pkg::ST_FAST_IN, fics_pkg::ST_FAST_OUT: begin
                if (lastFast) begin
                    stateNext = fics_pkg::ST_IDLE; // see RL12
                end
            end
            fics_pkg::ST_SLOW_IN: begin
                if (cntReg < 5'h03) begin
                    spNext = spReg - 8'h01;
                end
                if (lastSlow) begin
                    stateNext = fics_pkg::ST_IDLE; // see RL12
                    pcNext = vectorAddr;
                end
            end
            fics_pkg::ST_SLOW_OUT: begin
                if (cntReg < 5'h03) begin
                    spNext = spReg + 8'h01;
                end
                if (lastSlow) begin
                    stateNext = fics_pkg::ST_IDLE;
                    pcNext = savedPcReg;
                    flagsNext = savedFlagsReg;
                    modeNext[fics_pkg::MODE_GIE_BIT] = 1'b1;
                end
            end
            default: begin
                stateNext = fics_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            stateReg <= fics_pkg::ST_IDLE;
            cntReg <= 5'h00;
            modeReg <= fics_pkg::MODE_RESET;
            {pointerHighByteReg, pointerLowByteReg} <= fics_pkg::PTR_RESET;
            flagsReg <= fics_pkg::FLAGS_RESET;
            shadowReg <= fics_pkg::FLAGS_RESET;
            pcReg <= fics_pkg::PC_RESET;
            spReg <= fics_pkg::SP_RESET;
            savedPcReg <= fics_pkg::PC_RESET;
            savedFlagsReg <= fics_pkg::FLAGS_RESET;
        end else begin
            stateReg <= stateNext;
            cntReg <= cntNext;
            modeReg <= modeNext;
            pointerHighByteReg <= pointerHighByteNext;
            pointerLowByteReg <= pointerLowByteNext;
            flagsReg <= flagsNext;
            shadowReg <= shadowNext;
            pcReg <= pcNext;
            spReg <= spNext;
            savedPcReg <= savedPcNext;
            savedFlagsReg <= savedFlagsNext;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence fastEntry;
        takeFast ##1 (stateReg == fics_pkg::ST_FAST_IN);
    endsequence

    chk_fast_swap_pc: assert property (takeFast |=> pcReg == $past(servicePointer)) // see RL2
        else $error("fast entry did not load pointer into pc");
    chk_fast_swap_ptr: assert property (takeFast |=> servicePointer == $past(pcReg)) // see RL2
        else $error("fast entry did not save pc in pointer");
    chk_shadow_copy: assert property (takeFast |=> shadowReg == $past(flagsReg)) // see RL3
        else $error("flags not copied to shadow");
    chk_fast_flag_set: assert property (fastEntry |-> fastFlag) // see RL4
        else $error("fast flag not set on entry");
    chk_return_swap: assert property (retFast |=> pcReg == $past(servicePointer)) // see RL5
        else $error("fast return did not swap back");
    chk_flags_restore: assert property (retFast |=> flagsReg == ($past(shadowReg) & 8'hfd)) // see RL6
        else $error("flags not restored from shadow");
    chk_flag_cleared: assert property (retFast |=> !fastFlag) // see RL7
        else $error("fast flag not cleared on return");
    chk_global_gate: assert property (idle && !globalOn |=> stateReg != fics_pkg::ST_FAST_IN
        && stateReg != fics_pkg::ST_SLOW_IN) // see RL10
        else $error("interrupt taken with global enable off");
    chk_flag_inhibit: assert property (idle && fastFlag |=> stateReg != fics_pkg::ST_FAST_IN
        && stateReg != fics_pkg::ST_SLOW_IN) // see RL14
        else $error("interrupt taken while fast flag set");
    chk_fast_length: assert property (takeFast |=> busy [*6] ##1 !busy) // see RL12
        else $error("fast entry length wrong");
    chk_enable_only: assert property (takeIrq && !fastOn |=> stateReg == fics_pkg::ST_SLOW_IN) // see RL9
        else $error("fast path used while disabled");
    chk_slow_path: assert property (takeSlow |=> stateReg == fics_pkg::ST_SLOW_IN) // see RL16
        else $error("ordinary entry not used");
endmodule

//--- fics_irq_model.sv
// Partner model: interrupt request source and return strobe for the swap sequencer
`timescale 1ns/100ps
module fics_irq_model #(
    parameter logic [15:0] VECTOR = 16'h0c40
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Bench commands
    input wire logic reqOn,
    input wire logic [2:0] reqLvl,
    input wire logic autoClear,
    input wire logic retOn,
    // Sequencer side
    input wire logic irqAck,
    output logic irqValid,
    output logic [2:0] irqLevel,
    output logic [15:0] vectorAddr,
    output logic irqReturn
);
    logic servedReg;

    assign vectorAddr = VECTOR;

    // Hardware-cleared pending drops on acknowledge, software-cleared waits for the bench
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            servedReg <= 1'b0;
            irqValid <= 1'b0;
            irqLevel <= 3'h0;
            irqReturn <= 1'b0;
        end else begin
            servedReg <= reqOn && (servedReg || (irqAck && autoClear));
            irqValid <= reqOn && !(autoClear && (servedReg || irqAck));
            irqLevel <= reqLvl;
            irqReturn <= retOn;
        end
    end
endmodule

//--- tb_top.sv
// Testbench: APB and interrupt sequences against the fast context swap
`timescale 1ns/100ps
module tb_top;
    localparam logic [15:0] VEC = 16'h0c40;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pcLoad = 1'b0;
    logic reqOn = 1'b0, autoClear = 1'b0, retOn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdVal;
    logic [2:0] irqLevel, reqLvl = 3'h0;
    logic [15:0] vectorAddr, programCounter, pcIn = 16'h0000, pcFirst, ptrVal, pcVal;
    logic pready, pslverr, irqValid, irqAck, irqReturn, stackPush, stackPop, busy, errSeen;
    logic [7:0] stackPtr, flagsVal, modeVal;
    int fail_count = 0, checks_done = 0, cycleCount = 0, ackCount = 0;
    int busyN, pushN, popN, ackMark;

    always #2.5 ref_clk = ~ref_clk;

    fics_core dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irqValid(irqValid), .irqLevel(irqLevel), .vectorAddr(vectorAddr),
        .irqAck(irqAck), .irqReturn(irqReturn), .pcIn(pcIn), .pcLoad(pcLoad),
        .programCounter(programCounter), .stackPush(stackPush), .stackPop(stackPop),
        .stackPtr(stackPtr), .busy(busy));
    fics_irq_model #(.VECTOR(VEC)) partner (.ref_clk(ref_clk), .rst_b(rst_b), .reqOn(reqOn),
        .reqLvl(reqLvl), .autoClear(autoClear), .retOn(retOn), .irqAck(irqAck),
        .irqValid(irqValid), .irqLevel(irqLevel), .vectorAddr(vectorAddr),
        .irqReturn(irqReturn));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdVal = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        apb(1'b0, a, 8'h00);
        chk(n, {24'h000000, e}, rdVal);
    endtask

    task automatic setPc(input logic [15:0] v);
        @(posedge ref_clk);
        pcIn <= v;
        pcLoad <= 1'b1;
        @(posedge ref_clk);
        pcLoad <= 1'b0;
    endtask

    task automatic raise(input logic [2:0] lvl, input logic auto);
        @(posedge ref_clk);
        reqLvl <= lvl;
        autoClear <= auto;
        reqOn <= 1'b1;
    endtask

    task automatic waitAck();
        int w;
        w = 0;
        do begin
            @(posedge ref_clk);
            w++;
        end while (irqAck !== 1'b1 && w < 60);
        chk("irqAck", 32'h1, {31'h0, irqAck});
    endtask

    // Counts busy cycles and stack strobes from the edge that took the request
    task automatic waitBusy();
        busyN = 0;
        pushN = 0;
        popN = 0;
        @(negedge ref_clk);
        pcFirst = programCounter;
        while (busy === 1'b1 && busyN < 40) begin
            busyN++;
            pushN += int'(stackPush === 1'b1);
            popN += int'(stackPop === 1'b1);
            @(negedge ref_clk);
        end
    endtask

    task automatic doReturn();
        reqOn <= 1'b0;
        @(posedge ref_clk);
        retOn <= 1'b1;
        @(posedge ref_clk);
        retOn <= 1'b0;
        @(posedge ref_clk);
        waitBusy();
    endtask

    always @(posedge ref_clk) begin
        cycleCount++;
        if (irqAck === 1'b1) ackCount <= ackCount + 1;
        if (cycleCount == 6000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        // The six mapped registers sit at consecutive words from zero
        for (int i = 0; i < 6; i++) rd(8'(4 * i), 8'h00, "reset value");
        chk("pc reset", 32'h0100, {16'h0, programCounter});
        chk("sp reset", 32'hff, {24'h0, stackPtr});
        apb(1'b1, fics_pkg::ADDR_SHADOW, 8'h55);
        rd(fics_pkg::ADDR_SHADOW, 8'h00, "shadow read only");
        rd(8'h18, 8'h00, "unmapped data");
        chk("unmapped error", 32'h1, {31'h0, errSeen});
        chk("pready", 32'h1, {31'h0, pready});
        $display("test reset_and_map done");
        for (int lvl = 0; lvl < 8; lvl++) begin
            ptrVal = {8'h40 + 8'(lvl), 8'h80};
            pcVal = 16'h2000 + 16'(lvl);
            flagsVal = 8'h81 | 8'(lvl << 4);
            modeVal = 8'(lvl << 2) | 8'h03;
            apb(1'b1, fics_pkg::ADDR_PTR_HIGH, ptrVal[15:8]);
            apb(1'b1, fics_pkg::ADDR_PTR_LOW, ptrVal[7:0]);
            apb(1'b1, fics_pkg::ADDR_MODE, modeVal);
            apb(1'b1, fics_pkg::ADDR_FLAGS, flagsVal);
            setPc(pcVal);
            raise(3'(lvl), lvl % 2 == 0);
            waitAck();
            waitBusy();
            ackMark = ackCount;
            chk("pc entry", {16'h0, ptrVal}, {16'h0, pcFirst});
            chk("fast entry cycles", 32'd6, busyN);
            rd(fics_pkg::ADDR_PTR_HIGH, pcVal[15:8], "ptr high in");
            rd(fics_pkg::ADDR_PTR_LOW, pcVal[7:0], "ptr low in");
            rd(fics_pkg::ADDR_SHADOW, flagsVal, "shadow");
            rd(fics_pkg::ADDR_FLAGS, flagsVal | 8'h02, "flags in");
            rd(fics_pkg::ADDR_MODE, modeVal & 8'hfe, "mode in");
            // Global enable back on, so on odd, software-cleared levels only the fast flag holds the pending request off
            apb(1'b1, fics_pkg::ADDR_MODE, modeVal);
            repeat (3) @(posedge ref_clk);
            chk("ack while flagged", ackMark, ackCount);
            doReturn();
            chk("pc return", {16'h0, pcVal}, {16'h0, pcFirst});
            chk("fast return cycles", 32'd6, busyN);
            rd(fics_pkg::ADDR_FLAGS, flagsVal, "flags out");
            rd(fics_pkg::ADDR_PTR_HIGH, ptrVal[15:8], "ptr high out");
            rd(fics_pkg::ADDR_MODE, modeVal, "mode out");
            $display("test fast level %0d done", lvl);
        end
        for (int k = 0; k < 2; k++) begin
            modeVal = (k == 0) ? 8'h15 : 8'h0f;
            apb(1'b1, fics_pkg::ADDR_MODE, modeVal);
            setPc(16'h3000);
            raise(3'h5, 1'b1);
            waitAck();
            waitBusy();
            chk("slow entry cycles", 32'd16, busyN);
            chk("slow pushes", 32'd3, pushN);
            chk("vector pc", {16'h0, VEC}, {16'h0, programCounter});
            rd(fics_pkg::ADDR_FLAGS, flagsVal, "flags slow");
            doReturn();
            chk("slow return cycles", 32'd16, busyN);
            chk("slow pops", 32'd3, popN);
            chk("pc slow return", 32'h3000, {16'h0, programCounter});
            chk("sp slow return", 32'hff, {24'h0, stackPtr});
            $display("test slow path %0d done", k);
        end
        apb(1'b1, fics_pkg::ADDR_MODE, 8'h16);
        apb(1'b1, fics_pkg::ADDR_PTR_HIGH, 8'h55);
        apb(1'b1, fics_pkg::ADDR_PTR_LOW, 8'haa);
        setPc(16'h3100);
        raise(3'h5, 1'b0);
        ackMark = ackCount;
        repeat (12) @(posedge ref_clk);
        chk("ack gated", ackMark, ackCount);
        apb(1'b1, fics_pkg::ADDR_MODE, 8'h17);
        waitAck();
        waitBusy();
        chk("gated pc", 32'h55aa, {16'h0, pcFirst});
        doReturn();
        chk("gated return pc", 32'h3100, {16'h0, pcFirst});
        $display("test global gate done");
        tally_and_finish();
    end
endmodule
